//--- dv/nas_alu_asserts.sv
`timescale 1ns/1ps
module nas_alu_asserts (
  // Clock and control
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                aclken,
  // Instruction side
  input wire logic                op_valid,
  input wire logic                op_ready,
  input wire nas_pkg::nas_op_type op_code,
  input wire logic [3:0]          op_first,
  input wire logic [3:0]          op_second,
  input wire logic                op_first_is_mem,
  // Result side
  input wire logic [3:0]          wb_data,
  input wire logic                wb_reg_we,
  input wire logic                wb_mem_we,
  input wire logic                skip_req,
  // Read data channel
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata
);
  import nas_pkg::*;
  logic take;
  logic pulse;
  assign take  = op_valid && op_ready && aclken;
  assign pulse = wb_reg_we || wb_mem_we || skip_req;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_exec_gap;
    !op_ready ##1 op_ready;
  endsequence
  sequence s_no_store;
    !wb_reg_we && !wb_mem_we;
  endsequence
  property p_op_gap;
    take |=> s_exec_gap;
  endproperty
  property p_pulse_once;
    pulse |=> !pulse;
  endproperty
  property p_pulse_cause;
    pulse |-> $past(take, 2);
  endproperty
  property p_toggle;
    take && op_code == NAS_OP_TOGGLE |-> ##2
      (wb_data == ($past(op_first, 2) ^ $past(op_second, 2))) &&
      ($past(op_first_is_mem, 2) ? wb_mem_we : wb_reg_we);
  endproperty
  property p_test_no_store;
    take && op_code >= NAS_OP_SKIP_IF_BITS_SET && op_code <= NAS_OP_SKIP_IF_BELOW
      |-> ##2 s_no_store;
  endproperty
  property p_equal;
    take && op_code == NAS_OP_SKIP_IF_EQUAL && op_first == op_second |-> ##2 skip_req;
  endproperty
  property p_below;
    take && op_code == NAS_OP_SKIP_IF_BELOW |->
      ##2 skip_req == ($past(op_first, 2) < $past(op_second, 2));
  endproperty
  property p_rotate;
    take && op_code == NAS_OP_ROTATE_RIGHT_CARRY |->
      ##2 wb_reg_we && !skip_req && ({1'b0, wb_data[2:0]} == ($past(op_first, 2) >> 1));
  endproperty
  property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_op_gap: assert property (p_op_gap) else $error("op_ready gap wrong");
  a_pulse_once: assert property (p_pulse_once) else $error("pulse too long");
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without op");
  a_toggle: assert property (p_toggle) else $error("toggle result wrong");
  a_test_no_store: assert property (p_test_no_store) else $error("test stored");
  a_equal: assert property (p_equal) else $error("equal skip missing");
  a_below: assert property (p_below) else $error("below skip wrong");
  a_rotate: assert property (p_rotate) else $error("rotate wrong");
  a_read_hold: assert property (p_read_hold) else $error("read data moved");
endmodule

bind nas_alu nas_alu_asserts u_chk (.aclk, .aresetn, .aclken, .op_valid, .op_ready,
  .op_code, .op_first, .op_second, .op_first_is_mem, .wb_data, .wb_reg_we, .wb_mem_we,
  .skip_req, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

//--- dv/nas_alu_bench.sv
`timescale 1ns/1ps
`include "nas_defines.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module nas_alu_bench;
  import nas_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, op_valid = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  nas_op_type  op_code = NAS_OP_SUM;
  logic [3:0]  op_first = 4'h0, op_second = 4'h0, wb_data, gen_nibble, mem_nibble;
  logic        op_first_is_mem = 1'b0, op_ready, wb_reg_we, wb_mem_we, skip_req;
  logic        index_modify_enable, aclken = 1'b1;
  logic [7:0]  skip_count;
  int          fails = 0, cmp_count = 0, cycles = 0;

  nas_alu u_dut (.aclk, .aresetn, .aclken, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .op_valid, .op_ready, .op_code, .op_first, .op_second,
    .op_first_is_mem, .wb_data, .wb_reg_we, .wb_mem_we, .skip_req, .index_modify_enable);
  nas_seq_model u_seq (.aclk, .aresetn, .wb_data, .wb_reg_we, .wb_mem_we, .skip_req,
    .gen_nibble_reg(gen_nibble), .mem_nibble_reg(mem_nibble), .skip_count_reg(skip_count));

  always #10 aclk = ~aclk;

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      complete_run;
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done, b_seen;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      if (s_axi_awready && !aw_done) aw_done = 1'b1;
      if (s_axi_wready && !w_done) w_done = 1'b1;
      @(posedge aclk);
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (w_done) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      b_seen = s_axi_bvalid;
      if (b_seen) `CHK(s_axi_bresp, er)
      @(posedge aclk);
    end while (!b_seen);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    `CHK({s_axi_rresp, s_axi_rdata}, {er, ed})
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // Expected control is {skip, memory write, register write}
  task automatic op(input nas_op_type c, input logic [3:0] a, input logic [3:0] b,
                    input logic m, input logic [3:0] ed, input logic [2:0] ec);
    @(posedge aclk);
    op_code         <= c;
    op_first        <= a;
    op_second       <= b;
    op_first_is_mem <= m;
    op_valid        <= 1'b1;
    do @(negedge aclk); while (!op_ready);
    @(posedge aclk);
    op_valid <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
    `CHK({skip_req, wb_mem_we, wb_reg_we}, ec)
    if (ec[1:0] != 2'b00) `CHK(wb_data, ed)
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h0, `NAS_RESP_OKAY);
    rd(`NAS_MODE_NIBBLE_ADDR, 32'h0, `NAS_RESP_OKAY);
    op(NAS_OP_SUM, 4'h9, 4'h8, 1'b0, 4'h1, 3'b001);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h4, `NAS_RESP_OKAY);
    op(NAS_OP_SUM_WITH_CARRY, 4'h7, 4'h8, 1'b1, 4'h0, 3'b010);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h6, `NAS_RESP_OKAY);
    op(NAS_OP_DIFFERENCE, 4'h3, 4'h5, 1'b0, 4'hE, 3'b001);
    op(NAS_OP_DIFFERENCE_BORROW, 4'h5, 4'h4, 1'b1, 4'h0, 3'b010);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h2, `NAS_RESP_OKAY);
    wr(`NAS_FLAG_NIBBLE_ADDR, 32'hA, `NAS_RESP_OKAY);
    op(NAS_OP_SUM, 4'h8, 4'h8, 1'b0, 4'h0, 3'b000);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'hE, `NAS_RESP_OKAY);
    op(NAS_OP_SUM, 4'h1, 4'h1, 1'b1, 4'h0, 3'b000);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h8, `NAS_RESP_OKAY);
    op(NAS_OP_UNION, 4'h5, 4'hA, 1'b0, 4'hF, 3'b001);
    op(NAS_OP_INTERSECT, 4'hC, 4'h6, 1'b1, 4'h4, 3'b010);
    op(NAS_OP_TOGGLE, 4'hC, 4'h6, 1'b1, 4'hA, 3'b010);
    op(NAS_OP_SKIP_IF_EQUAL, 4'h5, 4'h5, 1'b1, 4'h0, 3'b100);
    op(NAS_OP_SKIP_IF_UNEQUAL, 4'h5, 4'h5, 1'b1, 4'h0, 3'b000);
    op(NAS_OP_SKIP_IF_UNEQUAL, 4'h5, 4'h6, 1'b1, 4'h0, 3'b100);
    op(NAS_OP_SKIP_IF_NOT_BELOW, 4'h5, 4'h5, 1'b1, 4'h0, 3'b100);
    op(NAS_OP_SKIP_IF_BELOW, 4'h5, 4'h5, 1'b1, 4'h0, 3'b000);
    op(NAS_OP_SKIP_IF_BELOW, 4'h3, 4'h5, 1'b1, 4'h0, 3'b100);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h8, `NAS_RESP_OKAY);
    op(NAS_OP_SKIP_IF_BITS_SET, 4'h7, 4'h6, 1'b1, 4'h0, 3'b100);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h0, `NAS_RESP_OKAY);
    wr(`NAS_FLAG_NIBBLE_ADDR, 32'h8, `NAS_RESP_OKAY);
    op(NAS_OP_SKIP_IF_BITS_SET, 4'h5, 4'h6, 1'b1, 4'h0, 3'b000);
    wr(`NAS_FLAG_NIBBLE_ADDR, 32'h8, `NAS_RESP_OKAY);
    op(NAS_OP_SKIP_IF_BITS_CLEAR, 4'h8, 4'h7, 1'b1, 4'h0, 3'b100);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h0, `NAS_RESP_OKAY);
    wr(`NAS_FLAG_NIBBLE_ADDR, 32'h6, `NAS_RESP_OKAY);
    op(NAS_OP_ROTATE_RIGHT_CARRY, 4'h6, 4'h0, 1'b0, 4'hB, 3'b001);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h2, `NAS_RESP_OKAY);
    op(NAS_OP_ROTATE_RIGHT_CARRY, 4'h1, 4'h0, 1'b0, 4'h0, 3'b001);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h6, `NAS_RESP_OKAY);
    wr(`NAS_MODE_NIBBLE_ADDR, 32'h1, `NAS_RESP_OKAY);
    wr(`NAS_FLAG_NIBBLE_ADDR, 32'h0, `NAS_RESP_OKAY);
    op(NAS_OP_SUM, 4'h7, 4'h5, 1'b0, 4'h2, 3'b001);
    op(NAS_OP_SUM, 4'hF, 4'hF, 1'b0, 4'hC, 3'b001);
    op(NAS_OP_DIFFERENCE, 4'h3, 4'h5, 1'b0, 4'h8, 3'b001);
    op(NAS_OP_DIFFERENCE, 4'h0, 4'hC, 1'b0, 4'hE, 3'b001);
    op(NAS_OP_TOGGLE, 4'h9, 4'h3, 1'b0, 4'hA, 3'b001);
    // Status word at offset zero ignores writes and reports the last operation
    wr(`NAS_ALU_STATE_ADDR, 32'hF, `NAS_RESP_OKAY);
    rd(`NAS_ALU_STATE_ADDR, 32'h60A, `NAS_RESP_OKAY);
    op(NAS_OP_SKIP_IF_NOT_BELOW, 4'hC, 4'h3, 1'b1, 4'h0, 3'b100);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h4, `NAS_RESP_OKAY);
    rd(`NAS_MODE_NIBBLE_ADDR, 32'h1, `NAS_RESP_OKAY);
    wr(`NAS_FLAG_NIBBLE_ADDR, 32'h1, `NAS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(index_modify_enable, 1'b1)
    rd(12'h100, 32'h0, `NAS_RESP_SLVERR);
    wr(12'h100, 32'h5, `NAS_RESP_SLVERR);
    rd(`NAS_FLAG_NIBBLE_ADDR, 32'h1, `NAS_RESP_OKAY);
    // Enable low: an offered instruction must not be taken or stored
    @(posedge aclk);
    aclken <= 1'b0;
    op(NAS_OP_UNION, 4'h1, 4'h2, 1'b0, 4'h0, 3'b000);
    @(posedge aclk);
    aclken <= 1'b1;
    `CHK(skip_count, 8'd7)
    `CHK(gen_nibble, 4'hA)
    `CHK(mem_nibble, 4'hA)
    complete_run;
  end
endmodule

//--- dv/nas_seq_model.sv
`timescale 1ns/1ps
module nas_seq_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Results from the unit
  input  wire logic [3:0] wb_data,
  input  wire logic       wb_reg_we,
  input  wire logic       wb_mem_we,
  input  wire logic       skip_req,
  // Observed far-side state
  output logic      [3:0] gen_nibble_reg,
  output logic      [3:0] mem_nibble_reg,
  output logic      [7:0] skip_count_reg
);
  // Register and memory take results only on their own strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_nibble_reg <= 4'h0;
      mem_nibble_reg <= 4'h0;
    end else begin
      if (wb_reg_we) gen_nibble_reg <= wb_data;
      if (wb_mem_we) mem_nibble_reg <= wb_data;
    end
  end
  // Each skip request adds one to the skip count
  always_ff @(posedge aclk) begin
    if (!aresetn) skip_count_reg <= 8'h00;
    else if (skip_req) skip_count_reg <= skip_count_reg + 8'h01;
  end
endmodule

//--- logic/nas_alu.sv
`timescale 1ns/1ps
`include "nas_defines.svh"

module nas_alu (
  // Clock, reset, enable
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  aclken,
  // AXI4-Lite write address
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  // AXI4-Lite read data
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Instruction from the sequencer
  input  wire logic                  op_valid,
  output logic                       op_ready,
  input  wire nas_pkg::nas_op_type   op_code,
  input  wire logic [3:0]            op_first,
  input  wire logic [3:0]            op_second,
  input  wire logic                  op_first_is_mem,
  // Results toward register, memory and sequencer
  output logic [3:0]                 wb_data,
  output logic                       wb_reg_we,
  output logic                       wb_mem_we,
  output logic                       skip_req,
  output logic                       index_modify_enable
);
  import nas_pkg::*;

  nas_state_type state_reg;
  nas_op_type    op_reg;
  logic [3:0]    temp_a_reg;
  logic [3:0]    temp_b_reg;
  logic          dest_mem_reg;
  logic          decimal_mode_reg;
  logic          discard_reg;
  logic          carry_reg;
  logic          null_reg;
  logic          ixe_reg;
  logic [3:0]    wb_data_reg;
  logic          wb_reg_we_reg;
  logic          wb_mem_we_reg;
  logic          skip_reg;
  logic          last_skip_reg;
  logic [3:0]    last_result_reg;
  nas_op_type    last_op_reg;

  logic          aw_held_reg;
  logic [11:0]   aw_addr_reg;
  logic          w_held_reg;
  logic [31:0]   w_data_reg;
  logic [3:0]    w_strb_reg;
  logic          bvalid_reg;
  logic [1:0]    bresp_reg;
  logic          rvalid_reg;
  logic [31:0]   rdata_reg;
  logic [1:0]    rresp_reg;

  logic          exec_fire;
  logic          wr_commit;
  logic          wr_mode;
  logic          wr_flag;
  logic [4:0]    sum_raw;
  logic [4:0]    diff_raw;
  logic [4:0]    cmp_raw;
  logic          is_arith;
  logic          is_sub;
  logic          carry_in;
  logic [3:0]    dec_nibble;
  logic          dec_carry;
  logic [3:0]    arith_nibble;
  logic          arith_carry;
  logic [3:0]    result_next;
  logic          store_next;
  logic          skip_next;

  // Sequencer handshake
  assign op_ready  = (state_reg == NAS_ST_IDLE);
  assign exec_fire = aclken && (state_reg == NAS_ST_EXEC);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= NAS_ST_IDLE;
    end else if (aclken) begin
      case (state_reg)
        NAS_ST_IDLE: begin
          if (op_valid) begin
            state_reg <= NAS_ST_EXEC;
          end
        end
        NAS_ST_EXEC: begin
          state_reg <= NAS_ST_IDLE;
        end
        default: begin
          state_reg <= NAS_ST_IDLE;
        end
      endcase
    end
  end

  // Operand capture into the temporaries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_reg       <= NAS_OP_SUM;
      temp_a_reg   <= 4'h0;
      temp_b_reg   <= 4'h0;
      dest_mem_reg <= 1'b0;
    end else if (aclken && op_ready && op_valid) begin
      op_reg       <= op_code;
      temp_a_reg   <= op_first;
      temp_b_reg   <= op_second;
      dest_mem_reg <= op_first_is_mem;
    end
  end

  // Arithmetic core
  assign is_arith = (op_reg == NAS_OP_SUM) || (op_reg == NAS_OP_SUM_WITH_CARRY) ||
                    (op_reg == NAS_OP_DIFFERENCE) || (op_reg == NAS_OP_DIFFERENCE_BORROW);
  assign is_sub   = (op_reg == NAS_OP_DIFFERENCE) || (op_reg == NAS_OP_DIFFERENCE_BORROW);
  assign carry_in = ((op_reg == NAS_OP_SUM_WITH_CARRY) ||
                     (op_reg == NAS_OP_DIFFERENCE_BORROW)) && carry_reg;
  assign sum_raw  = {1'b0, temp_a_reg} + {1'b0, temp_b_reg} + {4'h0, carry_in};
  assign diff_raw = {1'b0, temp_a_reg} - {1'b0, temp_b_reg} - {4'h0, carry_in};
  assign cmp_raw  = {1'b0, temp_a_reg} - {1'b0, temp_b_reg};

  nas_bcd_adjust u_bcd_adjust (
    .raw_value   (is_sub ? diff_raw : sum_raw),
    .is_subtract (is_sub),
    .dec_nibble  (dec_nibble),
    .dec_carry   (dec_carry)
  );

  // Decimal correction only for arithmetic
  assign arith_nibble = decimal_mode_reg ? dec_nibble :
                        (is_sub ? diff_raw[3:0] : sum_raw[3:0]);
  assign arith_carry  = decimal_mode_reg ? dec_carry :
                        (is_sub ? diff_raw[4] : sum_raw[4]);

  always_comb begin
    result_next = temp_a_reg;
    store_next  = 1'b0;
    skip_next   = 1'b0;
    case (op_reg)
      NAS_OP_SUM, NAS_OP_SUM_WITH_CARRY, NAS_OP_DIFFERENCE, NAS_OP_DIFFERENCE_BORROW: begin
        result_next = arith_nibble;
        store_next  = !discard_reg;
      end
      NAS_OP_UNION: begin
        result_next = temp_a_reg | temp_b_reg;
        store_next  = 1'b1;
      end
      NAS_OP_INTERSECT: begin
        result_next = temp_a_reg & temp_b_reg;
        store_next  = 1'b1;
      end
      NAS_OP_TOGGLE: begin
        result_next = temp_a_reg ^ temp_b_reg;
        store_next  = 1'b1;
      end
      NAS_OP_SKIP_IF_BITS_SET: begin
        skip_next = ((temp_a_reg & temp_b_reg) == temp_b_reg);
      end
      NAS_OP_SKIP_IF_BITS_CLEAR: begin
        skip_next = ((temp_a_reg & temp_b_reg) == 4'h0);
      end
      NAS_OP_SKIP_IF_EQUAL: begin
        skip_next = (cmp_raw[3:0] == 4'h0);
      end
      NAS_OP_SKIP_IF_UNEQUAL: begin
        skip_next = (cmp_raw[3:0] != 4'h0);
      end
      NAS_OP_SKIP_IF_NOT_BELOW: begin
        skip_next = !cmp_raw[4];
      end
      NAS_OP_SKIP_IF_BELOW: begin
        skip_next = cmp_raw[4];
      end
      NAS_OP_ROTATE_RIGHT_CARRY: begin
        result_next = {carry_reg, temp_a_reg[3:1]};
        store_next  = 1'b1;
      end
      default: begin
        result_next = temp_a_reg;
      end
    endcase
  end

  // Result and skip outputs, one-cycle pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wb_data_reg   <= 4'h0;
      wb_reg_we_reg <= 1'b0;
      wb_mem_we_reg <= 1'b0;
      skip_reg      <= 1'b0;
    end else if (aclken) begin
      wb_data_reg   <= exec_fire ? result_next : wb_data_reg;
      wb_reg_we_reg <= exec_fire && store_next && !dest_mem_reg;
      wb_mem_we_reg <= exec_fire && store_next && dest_mem_reg;
      skip_reg      <= exec_fire && skip_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_result_reg <= 4'h0;
      last_skip_reg   <= 1'b0;
      last_op_reg     <= NAS_OP_SUM;
    end else if (exec_fire) begin
      last_result_reg <= result_next;
      last_skip_reg   <= skip_next;
      last_op_reg     <= op_reg;
    end
  end

  assign wb_data             = wb_data_reg;
  assign wb_reg_we           = wb_reg_we_reg;
  assign wb_mem_we           = wb_mem_we_reg;
  assign skip_req            = skip_reg;
  assign index_modify_enable = ixe_reg;

  // Status flags: one storage, reached by the ALU and the bus; ALU update wins
  assign wr_commit = aclken && aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_mode   = wr_commit && w_strb_reg[0] && (aw_addr_reg == `NAS_MODE_NIBBLE_ADDR);
  assign wr_flag   = wr_commit && w_strb_reg[0] && (aw_addr_reg == `NAS_FLAG_NIBBLE_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      decimal_mode_reg <= 1'(`NAS_MODE_RESET >> `NAS_MODE_DECIMAL_BIT);
    end else if (wr_mode) begin
      decimal_mode_reg <= w_data_reg[`NAS_MODE_DECIMAL_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      discard_reg <= 1'b0;
    end else if (exec_fire && ((op_reg == NAS_OP_SKIP_IF_BITS_SET) ||
                               (op_reg == NAS_OP_SKIP_IF_BITS_CLEAR))) begin
      discard_reg <= 1'b0;
    end else if (wr_flag) begin
      discard_reg <= w_data_reg[`NAS_FLAG_DISCARD_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_reg <= 1'b0;
    end else if (exec_fire && is_arith) begin
      carry_reg <= arith_carry;
    end else if (exec_fire && (op_reg == NAS_OP_ROTATE_RIGHT_CARRY)) begin
      carry_reg <= temp_a_reg[0];
    end else if (wr_flag) begin
      carry_reg <= w_data_reg[`NAS_FLAG_CARRY_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      null_reg <= 1'b0;
    end else if (exec_fire && is_arith) begin
      if (arith_nibble != 4'h0) begin
        null_reg <= 1'b0;
      end else if (!discard_reg) begin
        null_reg <= 1'b1;
      end
    end else if (wr_flag) begin
      null_reg <= w_data_reg[`NAS_FLAG_NULL_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ixe_reg <= 1'b0;
    end else if (wr_flag) begin
      ixe_reg <= w_data_reg[`NAS_FLAG_IXE_BIT];
    end
  end

  // AXI4-Lite write path: address and data taken independently
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
    end else if (aclken) begin
      if (!aw_held_reg && s_axi_awvalid) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_commit) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (aclken) begin
      if (!w_held_reg && s_axi_wvalid) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_commit) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `NAS_RESP_OKAY;
    end else if (aclken) begin
      if (wr_commit) begin
        bvalid_reg <= 1'b1;
        if ((aw_addr_reg == `NAS_MODE_NIBBLE_ADDR) ||
            (aw_addr_reg == `NAS_FLAG_NIBBLE_ADDR) ||
            (aw_addr_reg == `NAS_ALU_STATE_ADDR)) begin
          bresp_reg <= `NAS_RESP_OKAY;
        end else begin
          bresp_reg <= `NAS_RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `NAS_RESP_OKAY;
    end else if (aclken) begin
      if (!rvalid_reg && s_axi_arvalid) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= `NAS_RESP_OKAY;
        rdata_reg  <= 32'h0000_0000;
        if (s_axi_araddr == `NAS_MODE_NIBBLE_ADDR) begin
          rdata_reg[`NAS_MODE_DECIMAL_BIT] <= decimal_mode_reg;
        end else if (s_axi_araddr == `NAS_FLAG_NIBBLE_ADDR) begin
          rdata_reg[3:0] <= {discard_reg, carry_reg, null_reg, ixe_reg};
        end else if (s_axi_araddr == `NAS_ALU_STATE_ADDR) begin
          rdata_reg[`NAS_STATE_RESULT_LSB +: 4] <= last_result_reg;
          rdata_reg[`NAS_STATE_SKIP_BIT]        <= last_skip_reg;
          rdata_reg[`NAS_STATE_OP_LSB +: 4]     <= last_op_reg;
        end else begin
          rresp_reg <= `NAS_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

endmodule

//--- logic/nas_bcd_adjust.sv
`timescale 1ns/1ps
`include "nas_defines.svh"

module nas_bcd_adjust (
  // Raw binary result, five bits, two's complement for subtraction
  input  wire logic [4:0] raw_value,
  input  wire logic       is_subtract,
  // Corrected nibble and carry or borrow
  output logic      [3:0] dec_nibble,
  output logic            dec_carry
);

  logic [1:0] wrap_low;

  assign wrap_low = raw_value[1:0] + `NAS_DEC_BIAS;

  always_comb begin
    dec_nibble = raw_value[3:0];
    dec_carry  = 1'b0;
    if (!is_subtract) begin
      if (raw_value < `NAS_DEC_TEN) begin
        dec_carry = 1'b0;
      end else if (raw_value < `NAS_DEC_TWENTY) begin
        dec_nibble = 4'(raw_value - `NAS_DEC_TEN);
        dec_carry  = 1'b1;
      end else begin
        // Out of decimal range: stored nibble lands at 1010B or above
        dec_nibble = {1'b1, ~(raw_value[3] & raw_value[2] & ~raw_value[1]), wrap_low};
        dec_carry  = 1'b1;
      end
    end else begin
      if (!raw_value[4] && raw_value < `NAS_DEC_TEN) begin
        dec_carry = 1'b0;
      end else if (raw_value[4] && raw_value >= 5'h16) begin
        // Result in -10 .. -1 borrows and wraps to 0 .. 9
        dec_nibble = 4'(raw_value + `NAS_DEC_TEN);
        dec_carry  = 1'b1;
      end else begin
        dec_nibble = {2'h3, wrap_low};
        dec_carry  = 1'b1;
      end
    end
  end

endmodule

//--- logic/nas_defines.svh
`ifndef NAS_DEFINES_SVH
`define NAS_DEFINES_SVH

// Register indices and byte addresses (byte address is four times the index)
`define NAS_MODE_NIBBLE_IDX   9'h07E
`define NAS_FLAG_NIBBLE_IDX   9'h07F
`define NAS_ALU_STATE_IDX     9'h000
`define NAS_MODE_NIBBLE_ADDR  12'h1F8
`define NAS_FLAG_NIBBLE_ADDR  12'h1FC
`define NAS_ALU_STATE_ADDR    12'h000

// Field positions
`define NAS_MODE_DECIMAL_BIT  0
`define NAS_FLAG_DISCARD_BIT  3
`define NAS_FLAG_CARRY_BIT    2
`define NAS_FLAG_NULL_BIT     1
`define NAS_FLAG_IXE_BIT      0
`define NAS_STATE_RESULT_LSB  0
`define NAS_STATE_SKIP_BIT    4
`define NAS_STATE_OP_LSB      8

// Reset values
`define NAS_MODE_RESET        4'h0
`define NAS_FLAG_RESET        4'h0

// Decimal correction constants
`define NAS_DEC_TEN           5'h0A
`define NAS_DEC_TWENTY        5'h14
`define NAS_DEC_BIAS          2'h2

// Bus responses
`define NAS_RESP_OKAY         2'h0
`define NAS_RESP_SLVERR       2'h2

`endif

//--- logic/nas_pkg.sv
package nas_pkg;

  typedef enum logic [3:0] {
    NAS_OP_SUM                 = 4'h0,
    NAS_OP_SUM_WITH_CARRY      = 4'h1,
    NAS_OP_DIFFERENCE          = 4'h2,
    NAS_OP_DIFFERENCE_BORROW   = 4'h3,
    NAS_OP_UNION               = 4'h4,
    NAS_OP_INTERSECT           = 4'h5,
    NAS_OP_TOGGLE              = 4'h6,
    NAS_OP_SKIP_IF_BITS_SET    = 4'h7,
    NAS_OP_SKIP_IF_BITS_CLEAR  = 4'h8,
    NAS_OP_SKIP_IF_EQUAL       = 4'h9,
    NAS_OP_SKIP_IF_UNEQUAL     = 4'hA,
    NAS_OP_SKIP_IF_NOT_BELOW   = 4'hB,
    NAS_OP_SKIP_IF_BELOW       = 4'hC,
    NAS_OP_ROTATE_RIGHT_CARRY  = 4'hD
  } nas_op_type;

  typedef enum logic [1:0] {
    NAS_ST_IDLE = 2'h0,
    NAS_ST_EXEC = 2'h1
  } nas_state_type;

endpackage
